// ### include/i2m_pkg.sv
// Contract
// - 2048 bytes addressed by 11 bits: 8-bit row plus 3-bit segment.
// - Writes finish inside the serial transfer; no ready polling ever needed.
// - Device is slave only and never drives the serial clock.
// - Data rising while clock high is STOP; aborts any operation.
// - Data falling while clock high is START; aborts and awaits slave address.
// - Driver changes data only while clock low, except START and STOP.
// - Transmitter releases data for ninth clock; receiver pulls low to acknowledge.
// - Data high during acknowledge clock ends operation; wait for new address.
// - First byte after START is slave address: type, page, direction.
// - Respond only when upper four address bits match device-type code.
// - Next three bits select page, forming upper address bits.
// - Least significant bit is direction: one read, zero write.
// - Write takes next byte as low address, latched with page as 11 bits.
// - Read takes no word address; page latched, low bits from latch.
// - Address latch increments after each data byte before acknowledge, wrapping.
// - No limit on consecutive bytes per read or write.
// - Read drives eight bits, samples acknowledge; continue or release bus.
// - Write shifts in eight bits then drives an acknowledge.
// - All bytes travel most significant bit first.
// - Drive data after falling clock edges; sample on rising edges.
// - Commit written byte after eighth bit, before acknowledge.
package i2m_pkg;
    localparam int ADDR_W = 11;
    localparam int ROW_W = 8;
    localparam int PAGE_W = 3;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 2048;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int PAGE_MSB = 3;
    localparam int PAGE_LSB = 1;
    localparam int RW_BIT = 0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // Arbitrary device-type code, not tied to any real part
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

    typedef enum logic [2:0] {
        I2M_IDLE,
        I2M_RX,
        I2M_ACK_SET,
        I2M_ACK_HOLD,
        I2M_TX,
        I2M_TX_ACK,
        I2M_TX_NEXT
    } i2m_state_t;

    typedef enum logic [1:0] {
        I2M_PH_DEV,
        I2M_PH_WORD,
        I2M_PH_DATA
    } i2m_phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } i2m_wr_t;
endpackage : i2m_pkg

// ### verilog/i2m_slave.sv
`timescale 1ns/1ps
module i2m_slave #(
    parameter logic [3:0] DEV_TYPE = i2m_pkg::DEV_TYPE_DEF
) (
    // System domain
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Link domain
    input wire logic link_clk_i,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Status toward system
    output logic busy_o,
    output logic wr_evt_o,
    output i2m_pkg::i2m_wr_t wr_info_o
);
    // Link-side reset, carried over from the system domain
    logic rst_meta;
    logic rst_l;
    always_ff @(posedge link_clk_i) begin
        rst_meta <= srst_i;
        rst_l <= rst_meta;
    end

    // Pin synchronisers; the slave never drives the clock
    logic scl_meta;
    logic scl_s;
    logic scl_prev;
    logic sda_meta;
    logic sda_s;
    logic sda_prev;
    always_ff @(posedge link_clk_i) begin
        scl_meta <= scl_i;
        scl_s <= scl_meta;
        sda_meta <= sda_i;
        sda_s <= sda_meta;
    end
    always_ff @(posedge link_clk_i) begin
        if (rst_l) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;
    wire scl_rise = scl_s & ~scl_prev;
    wire scl_fall = ~scl_s & scl_prev;

    // Memory and protocol state
    logic [i2m_pkg::DATA_W-1:0] mem [i2m_pkg::MEM_DEPTH];
    i2m_pkg::i2m_state_t state;
    i2m_pkg::i2m_phase_t phase;
    logic [2:0] bit_cnt;
    logic [i2m_pkg::DATA_W-1:0] shreg;
    logic [i2m_pkg::ADDR_W-1:0] addr;
    logic rw;
    logic wr_tog;
    i2m_pkg::i2m_wr_t wr_hold;

    wire [i2m_pkg::DATA_W-1:0] rx_byte = {shreg[i2m_pkg::DATA_W-2:0], sda_s};
    wire byte_done = (bit_cnt == i2m_pkg::BIT_LAST);
    wire type_ok = (rx_byte[i2m_pkg::TYPE_MSB:i2m_pkg::TYPE_LSB] == DEV_TYPE);
    wire [i2m_pkg::PAGE_W-1:0] rx_page = rx_byte[i2m_pkg::PAGE_MSB:i2m_pkg::PAGE_LSB];
    wire [i2m_pkg::ADDR_W-1:0] addr_inc = addr + 11'h001;
    wire [i2m_pkg::DATA_W-1:0] rd_byte = mem[addr];

    // Commit happens on the eighth rising edge, so an abort earlier leaves memory intact
    always_ff @(posedge link_clk_i) begin
        if (state == i2m_pkg::I2M_RX && phase == i2m_pkg::I2M_PH_DATA && scl_rise && byte_done
            && !start_det && !stop_det) begin
            mem[addr] <= rx_byte;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (rst_l) begin
            state <= i2m_pkg::I2M_IDLE;
            phase <= i2m_pkg::I2M_PH_DEV;
            bit_cnt <= i2m_pkg::BIT_FIRST;
            shreg <= 8'h00;
            addr <= 11'h000;
            rw <= 1'b0;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
            wr_tog <= 1'b0;
            wr_hold <= '0;
        end else if (start_det) begin
            state <= i2m_pkg::I2M_RX;
            phase <= i2m_pkg::I2M_PH_DEV;
            bit_cnt <= i2m_pkg::BIT_FIRST;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            state <= i2m_pkg::I2M_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (state)
                i2m_pkg::I2M_RX: begin
                    if (scl_rise) begin
                        shreg <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (byte_done) begin
                            state <= i2m_pkg::I2M_ACK_SET;
                            case (phase)
                                i2m_pkg::I2M_PH_DEV: begin
                                    // Foreign address must not disturb the latch
                                    if (!type_ok) begin
                                        state <= i2m_pkg::I2M_IDLE;
                                    end else begin
                                        rw <= rx_byte[i2m_pkg::RW_BIT];
                                        addr <= {rx_page, addr[i2m_pkg::ROW_W-1:0]};
                                    end
                                end
                                i2m_pkg::I2M_PH_WORD: begin
                                    addr <= {addr[i2m_pkg::ADDR_W-1:i2m_pkg::ROW_W], rx_byte};
                                end
                                default: begin
                                    addr <= addr_inc;
                                    wr_hold <= '{addr: addr, data: rx_byte};
                                    wr_tog <= ~wr_tog;
                                end
                            endcase
                        end
                    end
                end
                i2m_pkg::I2M_ACK_SET: begin
                    if (scl_fall) begin
                        sda_oe_o <= 1'b1;
                        state <= i2m_pkg::I2M_ACK_HOLD;
                    end
                end
                i2m_pkg::I2M_ACK_HOLD: begin
                    if (scl_fall) begin
                        bit_cnt <= i2m_pkg::BIT_FIRST;
                        if (phase == i2m_pkg::I2M_PH_DEV && rw) begin
                            shreg <= rd_byte;
                            sda_oe_o <= ~rd_byte[i2m_pkg::DATA_W-1];
                            state <= i2m_pkg::I2M_TX;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state <= i2m_pkg::I2M_RX;
                            phase <= (phase == i2m_pkg::I2M_PH_DEV) ? i2m_pkg::I2M_PH_WORD
                                                                    : i2m_pkg::I2M_PH_DATA;
                        end
                    end
                end
                i2m_pkg::I2M_TX: begin
                    if (scl_fall) begin
                        if (byte_done) begin
                            sda_oe_o <= 1'b0;
                            addr <= addr_inc;
                            state <= i2m_pkg::I2M_TX_ACK;
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                            shreg <= {shreg[i2m_pkg::DATA_W-2:0], 1'b0};
                            sda_oe_o <= ~shreg[i2m_pkg::DATA_W-2];
                        end
                    end
                end
                i2m_pkg::I2M_TX_ACK: begin
                    if (scl_rise) begin
                        state <= sda_s ? i2m_pkg::I2M_IDLE : i2m_pkg::I2M_TX_NEXT;
                    end
                end
                i2m_pkg::I2M_TX_NEXT: begin
                    if (scl_fall) begin
                        bit_cnt <= i2m_pkg::BIT_FIRST;
                        shreg <= rd_byte;
                        sda_oe_o <= ~rd_byte[i2m_pkg::DATA_W-1];
                        state <= i2m_pkg::I2M_TX;
                    end
                end
                i2m_pkg::I2M_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    state <= i2m_pkg::I2M_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // System-side view: busy as a level, commits as a toggle event.
    // Held word stays stable for a whole byte time, far longer than the crossing.
    wire link_busy = (state != i2m_pkg::I2M_IDLE);
    logic busy_meta;
    logic tog_meta;
    logic tog_s;
    logic tog_prev;
    always_ff @(posedge ref_clk_i) begin
        busy_meta <= link_busy;
        tog_meta <= wr_tog;
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            busy_o <= 1'b0;
            tog_s <= 1'b0;
            tog_prev <= 1'b0;
            wr_evt_o <= 1'b0;
            wr_info_o <= '0;
        end else begin
            busy_o <= busy_meta;
            tog_s <= tog_meta;
            tog_prev <= tog_s;
            wr_evt_o <= tog_s ^ tog_prev;
            if (tog_s ^ tog_prev) begin
                wr_info_o <= wr_hold;
            end
        end
    end
endmodule : i2m_slave

// ### verification/i2m_checker.sv
`timescale 1ns/1ps
module i2m_checker (
    // Clocks and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // Status
    input wire logic busy_o,
    input wire logic wr_evt_o,
    input wire i2m_pkg::i2m_wr_t wr_info_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive moved with clock high");
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("data driven high");
    a_oe_needs_busy: assert property (sda_oe_o |-> busy_o)
        else $error("data pulled low while idle");
    a_start_wakes: assert property ($fell(sda_i) && scl_i |-> ##[1:12] busy_o)
        else $error("start not taken");
    a_stop_idles: assert property ($rose(sda_i) && scl_i |-> ##[1:12] !busy_o)
        else $error("stop did not end transfer");
    a_evt_one_cycle: assert property (wr_evt_o |=> !wr_evt_o)
        else $error("write pulse too long");
    a_info_with_evt: assert property ($changed(wr_info_o) |-> wr_evt_o)
        else $error("write info moved without pulse");
    a_evt_in_txn: assert property (wr_evt_o |-> busy_o)
        else $error("write outside transfer");
    c_write: cover property (wr_evt_o);
    c_drive: cover property ($rose(sda_oe_o));
    c_end: cover property ($fell(busy_o));
endmodule : i2m_checker

bind i2m_slave i2m_checker chk (.ref_clk_i, .srst_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .busy_o, .wr_evt_o, .wr_info_o);

// ### verification/i2m_master_model.sv
`timescale 1ns/1ps
module i2m_master_model (
    // Timing
    input wire logic clk_i,
    // Serial wires
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Quarter bit of 5 cycles keeps each phase far above the sampler's minimum
    task automatic q();
        repeat (5) @(posedge clk_i);
    endtask : q
    task automatic start();
        sda_oe_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask : start
    task automatic stop();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b0;
        q();
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o <= ~b;
        q();
        scl_o <= 1'b1;
        q();
        r = sda_i;
        q();
        scl_o <= 1'b0;
        q();
    endtask : bit_x
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_in, ack);
    endtask : xfer
endmodule : i2m_master_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    // Arbitrary type code for the bench
    localparam logic [3:0] DEV = 4'h9;
    logic ref_clk_i;
    logic link_clk_i;
    logic srst_i;
    logic scl;
    logic m_oe;
    logic sda_o;
    logic sda_oe_o;
    logic busy_o;
    logic wr_evt_o;
    i2m_pkg::i2m_wr_t wr_info_o;
    i2m_pkg::i2m_wr_t wr_last;
    logic [7:0] rd;
    logic ack;
    int bad_count = 0;
    int compares = 0;
    int wr_n = 0;
    // Pull-up holds the line high unless someone pulls low
    wire logic sda = ~(m_oe | sda_oe_o);
    i2m_master_model m (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    i2m_slave #(.DEV_TYPE(DEV)) dut (.ref_clk_i, .srst_i, .link_clk_i, .scl_i(scl), .sda_i(sda), .sda_o,
        .sda_oe_o, .busy_o, .wr_evt_o, .wr_info_o);
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #3;
        forever #7.5 link_clk_i = ~link_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (wr_evt_o === 1'b1) begin
            wr_n <= wr_n + 1;
            wr_last <= wr_info_o;
        end
    end
    task automatic cmp(input string what, input logic [18:0] exp, input logic [18:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic send(input logic [7:0] b, input string what);
        m.xfer(b, 1'b1, rd, ack);
        cmp(what, 19'h0, {18'h0, ack});
    endtask : send
    task automatic t_write();
        m.start();
        send({DEV, 3'h7, 1'b0}, "addr ack");
        send(8'hff, "word ack");
        send(8'ha5, "data ack");
        cmp("commit 7ff", {11'h7ff, 8'ha5}, wr_last);
        send(8'h3c, "data ack");
        cmp("commit wrap", {11'h000, 8'h3c}, wr_last);
        send(8'h5a, "data ack");
        cmp("commit 001", {11'h001, 8'h5a}, wr_last);
        m.stop();
        cmp("write count", 19'h3, 19'(wr_n));
        $display("t_write done");
    endtask : t_write
    task automatic t_read();
        m.start();
        send({DEV, 3'h7, 1'b0}, "addr ack");
        send(8'hff, "word ack");
        m.start();
        send({DEV, 3'h7, 1'b1}, "read addr ack");
        m.xfer(8'hff, 1'b1, rd, ack);
        cmp("read 7ff", 19'ha5, {11'h0, rd});
        repeat (10) @(posedge ref_clk_i);
        cmp("idle after nack", 19'h0, {18'h0, busy_o});
        m.stop();
        m.start();
        send({DEV, 3'h0, 1'b1}, "read addr ack");
        m.xfer(8'hff, 1'b0, rd, ack);
        cmp("read 000", 19'h3c, {11'h0, rd});
        m.xfer(8'hff, 1'b1, rd, ack);
        cmp("read 001", 19'h5a, {11'h0, rd});
        m.stop();
        cmp("no write on read", 19'h3, 19'(wr_n));
        $display("t_read done");
    endtask : t_read
    task automatic t_bad_type();
        m.start();
        m.xfer({~DEV, 3'h0, 1'b0}, 1'b1, rd, ack);
        cmp("foreign addr ack", 19'h1, {18'h0, ack});
        m.stop();
        $display("t_bad_type done");
    endtask : t_bad_type
    task automatic t_abort();
        m.start();
        send({DEV, 3'h0, 1'b0}, "addr ack");
        send(8'h40, "word ack");
        for (int i = 0; i < 4; i++) m.bit_x(1'b0, ack);
        m.stop();
        repeat (10) @(posedge ref_clk_i);
        cmp("cut byte count", 19'h3, 19'(wr_n));
        cmp("idle after stop", 19'h0, {18'h0, busy_o});
        $display("t_abort done");
    endtask : t_abort
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        srst_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        t_write();
        t_read();
        t_bad_type();
        t_abort();
        final_report();
    end
    initial begin
        repeat (50000) @(posedge ref_clk_i);
        bad_count++;
        final_report();
    end
endmodule : tb
